/* File: rtl/fcsh_host.sv */
/*
  flash command host: takes one operation at a time from the user port and
  plays the matching command write/read cycles on the flash parallel bus.
  assumes the flash pins are synchronous to CLK and its bus is 16 bits wide.
*/
// Functional notes
// - commands written once on low byte only
// - ident read, address bit zero picks code
// - after 70H, reads return status word
// - program is setup 40H/10H then data
// - erase is 20H then D0H at block
// - reserved status bits masked when polling
// - supply low must be cleared before retry
// - clear status after any error flag
`timescale 1ns/1ns
`default_nettype none
`include "fcsh_consts.svh"
module fcsh_host #(
  parameter int AW = 20
) (
  input  wire logic                 CLK,
  input  wire logic                 RESETN,
  input  wire logic                 REQ_VALID,
  output logic                      REQ_READY,
  input  wire fcsh_pkg::fcsh_op_t   REQ_OP,
  input  wire logic [AW-1:0]        REQ_ADDR,
  input  wire logic [15:0]          REQ_DATA,
  output logic                      DONE,
  output logic [15:0]               RD_DATA,
  output fcsh_pkg::fcsh_status_t    STATUS,
  output logic                      SEQ_ERROR,
  output logic                      NEED_CLEAR,
  output logic [AW-1:0]             FL_ADDR,
  output logic [15:0]               FL_DQ_O,
  output logic                      FL_DQ_OE,
  input  wire logic [15:0]          FL_DQ_I,
  output logic                      FL_CE_N,
  output logic                      FL_WE_N,
  output logic                      FL_OE_N
);
  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {S_IDLE, S_WRITE, S_GAP, S_READ, S_DONE} st_t;
  localparam logic [7:0] STROBE = 8'(`FCSH_STROBE_CYC);

  st_t                 st_q, st_d;
  logic [7:0]          cnt_q, cnt_d;
  logic [1:0]          step_q, step_d;
  fcsh_pkg::fcsh_op_t  op_q, op_d;
  logic [AW-1:0]       addr_q, addr_d;
  logic [15:0]         data_q, data_d;
  logic [15:0]         rd_q, rd_d;
  logic                poll_q, poll_d;
  logic                susp_q, susp_d;
  logic                err_q, err_d;
  logic [7:0]          cmd;
  logic [AW-1:0]       cmd_addr;
  logic                last_wr;
  logic                want_rd;
  logic [7:0]          sr;

  assign sr = FL_DQ_I[7:0] & `FCSH_SR_VALID_MASK;

  // command byte and address for the current write step
  always_comb
  begin
    cmd      = `FCSH_CMD_READ_ARRAY;
    cmd_addr = '0;
    last_wr  = 1'b1;
    want_rd  = 1'b0;
    case (op_q)
      fcsh_pkg::FCSH_OP_READ_ARRAY:   cmd = `FCSH_CMD_READ_ARRAY;
      fcsh_pkg::FCSH_OP_READ_IDENT:
      begin
        cmd      = `FCSH_CMD_IDENT;
        cmd_addr = addr_q;
        want_rd  = 1'b1;
      end
      fcsh_pkg::FCSH_OP_READ_STATUS:
      begin
        cmd     = `FCSH_CMD_READ_STATUS;
        want_rd = 1'b1;
      end
      fcsh_pkg::FCSH_OP_CLEAR_STATUS: cmd = `FCSH_CMD_CLEAR_STATUS;
      fcsh_pkg::FCSH_OP_PROGRAM:
      begin
        cmd      = (step_q == 2'd0) ? `FCSH_CMD_PROG_SETUP : data_q[7:0];
        cmd_addr = addr_q;
        last_wr  = (step_q != 2'd0);
        want_rd  = 1'b1;
      end
      fcsh_pkg::FCSH_OP_ERASE:
      begin
        cmd      = (step_q == 2'd0) ? `FCSH_CMD_ERASE_SETUP : `FCSH_CMD_CONFIRM;
        cmd_addr = addr_q;
        last_wr  = (step_q != 2'd0);
        want_rd  = 1'b1;
      end
      fcsh_pkg::FCSH_OP_ABORT_ERASE:
      begin
        cmd      = (step_q == 2'd0) ? `FCSH_CMD_ERASE_SETUP : `FCSH_CMD_READ_ARRAY;
        cmd_addr = addr_q;
        last_wr  = (step_q != 2'd0);
        want_rd  = 1'b1;
      end
      // status command follows suspend: an idle engine may drop back to array reads
      fcsh_pkg::FCSH_OP_SUSPEND:
      begin
        cmd     = (step_q == 2'd0) ? `FCSH_CMD_SUSPEND : `FCSH_CMD_READ_STATUS;
        last_wr = (step_q != 2'd0);
        want_rd = 1'b1;
      end
      fcsh_pkg::FCSH_OP_RESUME:       cmd = `FCSH_CMD_CONFIRM;
      default:                        cmd = `FCSH_CMD_READ_ARRAY;
    endcase
  end

  // a user op is refused when the flash would not accept its command
  logic op_legal;
  always_comb
  begin
    op_legal = 1'b1;
    if (susp_q)
      op_legal = (REQ_OP == fcsh_pkg::FCSH_OP_READ_ARRAY) ||
                 (REQ_OP == fcsh_pkg::FCSH_OP_READ_STATUS) ||
                 (REQ_OP == fcsh_pkg::FCSH_OP_RESUME);
    else if (err_q)
      op_legal = (REQ_OP != fcsh_pkg::FCSH_OP_ERASE) &&
                 (REQ_OP != fcsh_pkg::FCSH_OP_PROGRAM);
  end

  assign REQ_READY = (st_q == S_IDLE) && op_legal;

  always_comb
  begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    step_d = step_q;
    op_d   = op_q;
    addr_d = addr_q;
    data_d = data_q;
    rd_d   = rd_q;
    poll_d = poll_q;
    susp_d = susp_q;
    err_d  = err_q;
    case (st_q)
      S_IDLE:
        if (REQ_VALID && REQ_READY)
        begin
          op_d   = REQ_OP;
          addr_d = REQ_ADDR;
          data_d = REQ_DATA;
          step_d = 2'd0;
          cnt_d  = STROBE;
          st_d   = S_WRITE;
        end
      S_WRITE:
        if (cnt_q > 8'd1)
          cnt_d = cnt_q - 8'd1;
        else
        begin
          cnt_d = STROBE;
          st_d  = S_GAP;
        end
      S_GAP:
        if (cnt_q > 8'd1)
          cnt_d = cnt_q - 8'd1;
        else if (!last_wr)
        begin
          step_d = step_q + 2'd1;
          cnt_d  = STROBE;
          st_d   = S_WRITE;
        end
        else if (want_rd)
        begin
          cnt_d  = STROBE;
          poll_d = (op_q != fcsh_pkg::FCSH_OP_READ_IDENT) &&
                   (op_q != fcsh_pkg::FCSH_OP_READ_STATUS);
          st_d   = S_READ;
        end
        else
        begin
          if (op_q == fcsh_pkg::FCSH_OP_RESUME)
            susp_d = 1'b0;
          if (op_q == fcsh_pkg::FCSH_OP_CLEAR_STATUS)
            err_d = 1'b0;
          st_d = S_DONE;
        end
      S_READ:
        if (cnt_q > 8'd1)
          cnt_d = cnt_q - 8'd1;
        else if (poll_q && !sr[`FCSH_SR_READY])
          cnt_d = STROBE;
        else
        begin
          rd_d = FL_DQ_I;
          if (poll_q)
          begin
            susp_d = sr[`FCSH_SR_SUSPEND];
            err_d  = err_q | sr[`FCSH_SR_ERASE_FAIL] | sr[`FCSH_SR_PROG_FAIL] |
                     sr[`FCSH_SR_SUPPLY_LOW];
          end
          st_d = S_DONE;
        end
      S_DONE:  st_d = S_IDLE;
      default: st_d = S_IDLE;
    endcase
  end

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      st_q   <= S_IDLE;
      cnt_q  <= 8'h00;
      step_q <= 2'd0;
      op_q   <= fcsh_pkg::FCSH_OP_READ_ARRAY;
      addr_q <= '0;
      data_q <= 16'h0000;
      rd_q   <= 16'h0000;
      poll_q <= 1'b0;
      susp_q <= 1'b0;
      err_q  <= 1'b0;
    end
    else
    begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      step_q <= step_d;
      op_q   <= op_d;
      addr_q <= addr_d;
      data_q <= data_d;
      rd_q   <= rd_d;
      poll_q <= poll_d;
      susp_q <= susp_d;
      err_q  <= err_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  logic in_wr;
  assign in_wr    = (st_q == S_WRITE);
  assign FL_CE_N  = !(in_wr || st_q == S_READ);
  assign FL_WE_N  = !in_wr;
  assign FL_OE_N  = !(st_q == S_READ);
  assign FL_DQ_OE = in_wr || (st_q == S_GAP);
  assign FL_DQ_O  = (op_q == fcsh_pkg::FCSH_OP_PROGRAM && step_q != 2'd0) ?
                    data_q : {8'h00, cmd};
  assign FL_ADDR  = cmd_addr;
  assign DONE     = (st_q == S_DONE);
  assign RD_DATA  = rd_q;
  assign STATUS   = {rd_q[`FCSH_SR_READY], rd_q[`FCSH_SR_SUSPEND],
                     rd_q[`FCSH_SR_ERASE_FAIL], rd_q[`FCSH_SR_PROG_FAIL],
                     rd_q[`FCSH_SR_SUPPLY_LOW]};
  assign SEQ_ERROR  = rd_q[`FCSH_SR_ERASE_FAIL] & rd_q[`FCSH_SR_PROG_FAIL];
  assign NEED_CLEAR = err_q;
endmodule : fcsh_host
`default_nettype wire

/* File: rtl/fcsh_consts.svh */
/*
  constants for the flash command host: command codes, status bit positions,
  bus timing counts. assumes a 50 MHz controller clock.
*/
`ifndef FCSH_CONSTS_SVH
`define FCSH_CONSTS_SVH
`define FCSH_CMD_READ_ARRAY   8'hff
`define FCSH_CMD_IDENT        8'h90
`define FCSH_CMD_READ_STATUS  8'h70
`define FCSH_CMD_CLEAR_STATUS 8'h50
`define FCSH_CMD_PROG_SETUP   8'h40
`define FCSH_CMD_PROG_ALT     8'h10
`define FCSH_CMD_ERASE_SETUP  8'h20
`define FCSH_CMD_CONFIRM      8'hd0
`define FCSH_CMD_SUSPEND      8'hb0
`define FCSH_SR_READY         7
`define FCSH_SR_SUSPEND       6
`define FCSH_SR_ERASE_FAIL    5
`define FCSH_SR_PROG_FAIL     4
`define FCSH_SR_SUPPLY_LOW    3
`define FCSH_SR_VALID_MASK    8'hf8
`define FCSH_CLK_MHZ          50
`define FCSH_T_STROBE_NS      60
`define FCSH_STROBE_CYC       ((`FCSH_T_STROBE_NS * `FCSH_CLK_MHZ + 999) / 1000)
`endif

/* File: rtl/fcsh_pkg.sv */
/*
  types for the flash command host.
  assumes fcsh_consts.svh is used alongside it.
*/
package fcsh_pkg;
  typedef enum logic [3:0] {
    FCSH_OP_READ_ARRAY,
    FCSH_OP_READ_IDENT,
    FCSH_OP_READ_STATUS,
    FCSH_OP_CLEAR_STATUS,
    FCSH_OP_PROGRAM,
    FCSH_OP_ERASE,
    FCSH_OP_SUSPEND,
    FCSH_OP_RESUME,
    FCSH_OP_ABORT_ERASE
  } fcsh_op_t;

  typedef struct packed {
    logic engine_ready_flag;
    logic suspend_flag;
    logic erase_fail_flag;
    logic program_fail_flag;
    logic supply_low_flag;
  } fcsh_status_t;
endpackage : fcsh_pkg

/* File: testbench/fcsh_flash_model.sv */
/* flash device model: commands, status word, ident codes.
   assumes host strobes move on rising clk edges; it samples on falling ones. */
`timescale 1ns/1ns
`default_nettype none
module fcsh_flash_model #(
  parameter int          BUSY = 12,
  parameter logic [15:0] MFR  = 16'h00a5, // arbitrary
  parameter logic [15:0] DEV  = 16'h005c  // arbitrary
) (
  input  wire logic        clk,
  input  wire logic [19:0] a,
  input  wire logic [15:0] d,
  input  wire logic        ce_n,
  input  wire logic        we_n,
  input  wire logic        oe_n,
  input  wire logic        low,
  input  wire logic        vfail,
  output logic [15:0]      q
);
  logic [7:0]  sr = 8'h80;
  logic [7:0]  c;
  logic [15:0] d_q;
  logic [15:0] last = 16'h0000;
  logic        we_q = 1'h1;
  logic        er = 1'h0;
  logic        sus = 1'h0;
  int          md = 0;
  int          pend = 0;
  int          cnt = 0;
  // reserved bits carry junk; released bus shows inverse of last word
  assign q = (!ce_n && !oe_n) ? (md == 2 ? {8'hc3, sr[7:3], 3'h5} :
             md == 1 ? (a[0] ? DEV : MFR) : a[15:0]) : ~last;
  always @(negedge clk)
  begin
    if (!ce_n && !oe_n)
      last <= q;
    we_q <= we_n;
    if (!we_n)
      d_q <= d;
    if (cnt > 0 && !sus)
      cnt--;
    if (cnt == 0)
      sr[7] = 1'h1;
    if (!we_q && we_n)
    begin
      c = d_q[7:0];
      if (pend != 0)
      begin
        md = 2;
        if (pend == 1 || c == 8'hd0)
        begin
          er = pend == 2;
          cnt = BUSY;
          sr[7] = 1'h0;
          sr[5:3] = sr[5:3] | {er & (low | vfail), !er & (low | vfail), low};
        end
        else
          sr[5:4] = 2'h3;
        pend = 0;
      end
      else if (sus)
        case (c)
          8'hd0: {sus, sr[7:6]} = 3'h0;
          8'hff: md = 0;
          8'h70: md = 2;
          default: ;
        endcase
      else if (!sr[7])
      begin
        if (c == 8'h70)
          md = 2;
        if (c == 8'hb0 && er)
          {sus, sr[7:6]} = 3'h7;
      end
      else
        case (c)
          8'hff: md = 0;
          8'h90: md = 1;
          8'h70: md = 2;
          8'h50: sr[5:3] = 3'h0;
          8'h40, 8'h10: pend = 1;
          8'h20: pend = 2;
          default: ;
        endcase
    end
  end
endmodule : fcsh_flash_model
`default_nettype wire

/* File: testbench/fcsh_host_monitor.sv */
/* port checker for fcsh_host, bound to every instance. */
`timescale 1ns/1ns
`default_nettype none
module fcsh_host_monitor (
  input wire logic                   CLK,
  input wire logic                   RESETN,
  input wire logic                   REQ_READY,
  input wire fcsh_pkg::fcsh_op_t     REQ_OP,
  input wire logic                   DONE,
  input wire logic [15:0]            RD_DATA,
  input wire fcsh_pkg::fcsh_status_t STATUS,
  input wire logic                   SEQ_ERROR,
  input wire logic                   NEED_CLEAR,
  input wire logic                   FL_DQ_OE,
  input wire logic                   FL_CE_N,
  input wire logic                   FL_WE_N,
  input wire logic                   FL_OE_N
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  a_write_frame: assert property (!FL_WE_N |-> !FL_CE_N && FL_OE_N && FL_DQ_OE)
    else $error("write frame");
  a_write_len: assert property ($fell(FL_WE_N) |-> !FL_WE_N [*3] ##1 FL_WE_N)
    else $error("write length");
  a_read_frame: assert property (!FL_OE_N |-> !FL_CE_N && !FL_DQ_OE)
    else $error("read frame");
  a_seq_flag: assert property (SEQ_ERROR == (RD_DATA[5] && RD_DATA[4]))
    else $error("sequence flag");
  a_status_map: assert property (STATUS == RD_DATA[7:3])
    else $error("status map");
  a_clear_gate: assert property (NEED_CLEAR && REQ_OP inside
    {fcsh_pkg::FCSH_OP_PROGRAM, fcsh_pkg::FCSH_OP_ERASE} |-> !REQ_READY)
    else $error("taken before clear");
  a_flag_ready: assert property ($rose(NEED_CLEAR) |-> RD_DATA[7])
    else $error("flag while busy");
  a_clear_done: assert property ($fell(NEED_CLEAR) |-> DONE || $past(DONE))
    else $error("flag dropped alone");
endmodule : fcsh_host_monitor
bind fcsh_host fcsh_host_monitor u_fcsh_host_monitor (.CLK(CLK), .RESETN(RESETN),
  .REQ_READY(REQ_READY), .REQ_OP(REQ_OP), .DONE(DONE), .RD_DATA(RD_DATA), .STATUS(STATUS),
  .SEQ_ERROR(SEQ_ERROR), .NEED_CLEAR(NEED_CLEAR), .FL_DQ_OE(FL_DQ_OE), .FL_CE_N(FL_CE_N),
  .FL_WE_N(FL_WE_N), .FL_OE_N(FL_OE_N));
`default_nettype wire

/* File: testbench/tb_fcsh_host.sv */
/* self-checking bench: random program/erase/abort against the flash model.
   assumes package, design, model and checker compiled first. */
`timescale 1ns/1ns
`default_nettype none
module tb_fcsh_host;
  logic clk = 1'h0;
  logic resetn = 1'h0;
  logic req_valid = 1'h0;
  logic low = 1'h0;
  logic vfail = 1'h0;
  fcsh_pkg::fcsh_op_t req_op = fcsh_pkg::FCSH_OP_READ_STATUS;
  fcsh_pkg::fcsh_op_t ops[4] = '{fcsh_pkg::FCSH_OP_PROGRAM, fcsh_pkg::FCSH_OP_ERASE,
    fcsh_pkg::FCSH_OP_ABORT_ERASE, fcsh_pkg::FCSH_OP_READ_IDENT};
  logic [19:0] req_addr = 20'h00000;
  logic [15:0] req_data = 16'h0000;
  logic [15:0] dq_o, dq_m, rd_data;
  logic [19:0] fl_addr;
  logic req_ready, done, seq_error, need_clear, dq_oe, ce_n, we_n, oe_n;
  fcsh_pkg::fcsh_status_t status;
  int miscompares = 0;
  int total_checks = 0;
  wire logic [15:0] dq = dq_oe ? dq_o : dq_m;
  always #10 clk = ~clk;
  fcsh_host u_fcsh_host (.CLK(clk), .RESETN(resetn), .REQ_VALID(req_valid),
    .REQ_READY(req_ready), .REQ_OP(req_op), .REQ_ADDR(req_addr), .REQ_DATA(req_data),
    .DONE(done), .RD_DATA(rd_data), .STATUS(status), .SEQ_ERROR(seq_error),
    .NEED_CLEAR(need_clear), .FL_ADDR(fl_addr), .FL_DQ_O(dq_o), .FL_DQ_OE(dq_oe),
    .FL_DQ_I(dq), .FL_CE_N(ce_n), .FL_WE_N(we_n), .FL_OE_N(oe_n));
  fcsh_flash_model u_fcsh_flash_model (.clk(clk), .a(fl_addr), .d(dq), .ce_n(ce_n),
    .we_n(we_n), .oe_n(oe_n), .low(low), .vfail(vfail), .q(dq_m));
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic do_op(input fcsh_pkg::fcsh_op_t op, input logic [19:0] a);
    int n;
    @(posedge clk);
    req_op <= op;
    req_addr <= a;
    req_data <= 16'($urandom);
    req_valid <= 1'h1;
    n = 0;
    @(negedge clk);
    while (req_ready !== 1'h1 && n < 500)
    begin
      @(negedge clk);
      n++;
    end
    if (n == 500)
      miscompares++;
    @(posedge clk);
    req_valid <= 1'h0;
    n = 0;
    @(negedge clk);
    while (done !== 1'h1 && n < 3000)
    begin
      @(negedge clk);
      n++;
    end
    if (n == 3000)
      miscompares++;
  endtask : do_op
  // expected status as seen on STATUS: ready, suspend, erase, program, supply
  function automatic logic [15:0] exp_st(int k, logic l, logic f);
    if (k == 2)
      return 16'h0016;
    return {12'h001, 1'h0, k == 1 && (l | f), k == 0 && (l | f), l};
  endfunction : exp_st
  task automatic end_of_test;
    if (miscompares == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  initial
  begin
    repeat (40000) @(posedge clk);
    miscompares++;
    end_of_test;
  end
  initial
  begin
    int k;
    logic lo, vf;
    void'($urandom(41797));
    repeat (16) @(posedge clk);
    resetn <= 1'h1;
    for (int i = 0; i < 2; i++)
    begin
      do_op(ops[3], {19'($urandom), i[0]});
      check("ident", rd_data, i ? 16'h005c : 16'h00a5);
    end
    do_op(fcsh_pkg::FCSH_OP_READ_ARRAY, 20'h00000);
    do_op(fcsh_pkg::FCSH_OP_SUSPEND, 20'h00000);
    check("suspend", 16'(status), 16'h0010);
    do_op(fcsh_pkg::FCSH_OP_RESUME, 20'h00000);
    do_op(fcsh_pkg::FCSH_OP_READ_STATUS, 20'($urandom));
    check("idle", 16'(status), 16'h0010);
    for (int i = 0; i < 16; i++)
    begin
      k = $urandom_range(2);
      lo = $urandom_range(3) == 0;
      vf = $urandom_range(3) == 0;
      low <= lo;
      vfail <= vf;
      do_op(ops[k], 20'($urandom));
      check("result", 16'(status), exp_st(k, lo, vf));
      check("seq", 16'(seq_error), 16'(k == 2));
      if (lo | vf | k == 2)
      begin
        do_op(fcsh_pkg::FCSH_OP_READ_STATUS, 20'($urandom));
        check("sticky", 16'(status), exp_st(k, lo, vf));
        check("need", 16'(need_clear), 16'h0001);
        @(posedge clk);
        req_op <= ops[k % 2];
        @(negedge clk);
        check("refuse", 16'(req_ready), 16'h0000);
        do_op(fcsh_pkg::FCSH_OP_CLEAR_STATUS, 20'h00000);
        do_op(fcsh_pkg::FCSH_OP_READ_STATUS, 20'($urandom));
        check("cleared", 16'({status, need_clear}), 16'h0020);
      end
    end
    end_of_test;
  end
endmodule : tb_fcsh_host
`default_nettype wire
